/* design/dcc_pkg.sv */
// package for the d-channel control channel master and transmit selector
// assumes a 32-channel serial interface and an axi4-lite register bus
package dcc_pkg;
	localparam int NUM_CH = 32;                                   // d-channels served
	localparam int CH_W   = 5;                                    // channel/port field width
	localparam int ADDR_W = 8;                                    // byte address width
	// register byte offsets
	localparam logic [7:0] OFF_MODE   = 8'h00;                    // arbiter_mode_register
	localparam logic [7:0] OFF_DCE    = 8'h04;                    // channel_enable_mask
	localparam logic [7:0] OFF_DEST   = 8'h08;                    // transmit_destination_register
	localparam logic [7:0] OFF_BCG    = 8'h0C;                    // broadcast_group_registers
	localparam logic [7:0] OFF_SHADOW = 8'h10;                    // channel_enable_shadow, read only
	localparam logic [7:0] OFF_STATE  = 8'h14;                    // arbiter_state_register view
	localparam logic [7:0] OFF_CM     = 8'h80;                    // control memory, 32 words
	// field positions
	localparam int MODE_MASTER_BIT = 0;                           // master_enable_bit
	localparam int MODE_CODING_BIT = 1;                           // control_coding_select
	localparam int DEST_BCAST_BIT  = 7;                           // broadcast select in destination
	localparam int CI_BLOCK_BIT    = 2;                           // c/i bit that says blocked
	localparam int STATE_SUSP_BIT  = 10;                          // effective suspension flag
	// reset values
	localparam logic [1:0]  MODE_RST = 2'h0;
	localparam logic [31:0] MASK_RST = 32'h0000_0000;
	localparam logic [7:0]  DEST_RST = 8'h00;
	// clock mode under which the arbiter may leave suspension
	localparam logic [2:0] ARB_CLK_MODE = 3'h3;
	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// assignment state machine states, one-hot
	typedef enum logic [4:0] {
		ST_SUSPENDED = 5'h01,
		ST_FULL      = 5'h02,
		ST_LIMITED   = 5'h04,
		ST_EXPECT    = 5'h08,
		ST_RECEIVE   = 5'h10
	} dcc_asm_state_t;
	// one control channel word: monitor_ready_bit plus c/i field
	typedef struct packed {
		logic       mr;
		logic [3:0] ci;
	} dcc_cc_word_t;
	// per-slot output carrier
	typedef struct packed {
		logic [CH_W-1:0] channel;
		dcc_cc_word_t    word;
	} dcc_cc_slot_t;
endpackage

/* design/dcc_ctrl_mem.sv */
// control memory: 32 control channel words, one write port, two read ports
// assumes a single clock; read data appear one edge after the address
`timescale 1ns/10ps
`default_nettype none
module dcc_ctrl_mem (
	input  wire logic                     clk,
	input  wire logic                     we,
	input  wire logic [dcc_pkg::CH_W-1:0] waddr,
	input  wire dcc_pkg::dcc_cc_word_t    wdata,
	input  wire logic [dcc_pkg::CH_W-1:0] raddr_a,
	output var  dcc_pkg::dcc_cc_word_t    rdata_a,
	input  wire logic [dcc_pkg::CH_W-1:0] raddr_b,
	output var  dcc_pkg::dcc_cc_word_t    rdata_b
);
	dcc_pkg::dcc_cc_word_t mem [dcc_pkg::NUM_CH];  // storage, no reset: software fills it

	// write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered reads, slot port and bus port
	always_ff @(posedge clk) begin
		rdata_a <= mem[raddr_a];
		rdata_b <= mem[raddr_b];
	end
endmodule // dcc_ctrl_mem
`default_nettype wire

/* design/dcc_master.sv */
// control channel master and transmit channel selector with axi4-lite registers
// assumes the assignment state machine, slot timing and frame commands come from
// neighbouring logic on the same clock; inputs are synchronous to clk
//
// The address map and the AXI4-Lite slave port were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// How it works
// - unenabled channel gets control memory value
// - suspended with master enable: memory value
// - master enable off: masked channels available
// - full selection: masked channels available, immediately
// - limited selection: mask AND shadow
// - expect/receive: only addressed channel may pass
// - clearing addressed mask bit blocks it now
// - coding select picks mr or c/i code
// - master enable off: independent of clock mode
// - available channel: generated available code
// - blocked channel: memory value unchanged
// - mask-cleared channel always gets memory value
// - route frame to channel or broadcast group
// - back-to-back frames need no idle gap
// - clock mode other than 3 means suspended
// - end of frame clears served shadow bit
module dcc_master (
	input  wire logic                          clk,
	input  wire logic                          reset,
	// axi4-lite slave
	input  wire logic [dcc_pkg::ADDR_W-1:0]    s_axi_awaddr,
	input  wire logic                          s_axi_awvalid,
	output var  logic                          s_axi_awready,
	input  wire logic [31:0]                   s_axi_wdata,
	input  wire logic [3:0]                    s_axi_wstrb,
	input  wire logic                          s_axi_wvalid,
	output var  logic                          s_axi_wready,
	output var  logic [1:0]                    s_axi_bresp,
	output var  logic                          s_axi_bvalid,
	input  wire logic                          s_axi_bready,
	input  wire logic [dcc_pkg::ADDR_W-1:0]    s_axi_araddr,
	input  wire logic                          s_axi_arvalid,
	output var  logic                          s_axi_arready,
	output var  logic [31:0]                   s_axi_rdata,
	output var  logic [1:0]                    s_axi_rresp,
	output var  logic                          s_axi_rvalid,
	input  wire logic                          s_axi_rready,
	// assignment state machine side
	input  wire dcc_pkg::dcc_asm_state_t       asm_state,
	input  wire logic [dcc_pkg::CH_W-1:0]      asm_channel,
	input  wire logic [2:0]                    hdlc_clock_mode,
	input  wire logic                          shadow_load,
	input  wire logic                          end_of_frame,
	// control channel slot request and answer
	input  wire logic                          slot_strobe,
	input  wire logic [dcc_pkg::CH_W-1:0]      slot_channel,
	output var  logic                          cc_valid,
	output var  dcc_pkg::dcc_cc_slot_t         cc_slot,
	// transmit channel selector
	input  wire logic                          transmit_frame_command,
	output var  logic                          tx_select_valid,
	output var  logic [dcc_pkg::NUM_CH-1:0]    tx_select_mask
);
	////////////////////////////////////////////////////////////////////////////
	// registers
	logic [1:0]                 mode_reg;       // master enable, coding select
	logic [31:0]                dce_reg;        // channel_enable_mask
	logic [31:0]                shadow_reg;     // channel_enable_shadow
	logic [7:0]                 dest_reg;       // transmit_destination_register
	logic [31:0]                bcg_reg;        // broadcast_group_registers
	// axi state
	logic [dcc_pkg::ADDR_W-1:0] aw_addr_reg;    // captured write address
	logic                       aw_have_reg;    // write address held
	logic [31:0]                w_data_reg;     // captured write data
	logic [3:0]                 w_strb_reg;     // captured strobes
	logic                       w_have_reg;     // write data held
	logic [dcc_pkg::ADDR_W-1:0] ar_addr_reg;    // captured read address
	logic                       rd_pend_reg;    // waiting one edge for memory
	logic                       rd_mem_reg;     // memory word of the new address arriving
	// slot pipeline
	logic                       s1_valid_reg;   // memory read under way
	logic [dcc_pkg::CH_W-1:0]   s1_ch_reg;      // its channel
	dcc_pkg::dcc_cc_word_t      cm_slot;        // memory word for the slot
	dcc_pkg::dcc_cc_word_t      cm_bus;         // memory word for the bus
	logic                       do_write;       // both halves of a write held
	logic                       cm_we;          // write targets control memory
	logic                       suspended;      // effective suspension
	logic                       avail;          // arbiter grants the slot channel
	dcc_pkg::dcc_cc_word_t      word_next;      // word going out

	// merge a write word under byte strobes
	function automatic logic [31:0] apply_strb(input logic [31:0] old_v, input logic [31:0] new_v,
		input logic [3:0] strb);
		logic [31:0] r;
		r = old_v;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = new_v[i*8 +: 8];
			end
		end
		return r;
	endfunction

	// true when a byte address falls inside the control memory window
	function automatic logic is_cm(input logic [dcc_pkg::ADDR_W-1:0] a);
		return a[7] == dcc_pkg::OFF_CM[7];
	endfunction

	// address of a mapped register; any byte address in the control memory window counts
	function automatic logic is_mapped(input logic [dcc_pkg::ADDR_W-1:0] a);
		return is_cm(a) || a == dcc_pkg::OFF_MODE || a == dcc_pkg::OFF_DCE || a == dcc_pkg::OFF_DEST
			|| a == dcc_pkg::OFF_BCG || a == dcc_pkg::OFF_SHADOW || a == dcc_pkg::OFF_STATE;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// control memory
	assign do_write = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign cm_we    = do_write && is_cm(aw_addr_reg) && w_strb_reg[0];

	dcc_ctrl_mem u_mem (
		.clk     (clk),
		.we      (cm_we),
		.waddr   (aw_addr_reg[6:2]),
		.wdata   (dcc_pkg::dcc_cc_word_t'(w_data_reg[4:0])),
		.raddr_a (slot_channel),
		.rdata_a (cm_slot),
		.raddr_b (ar_addr_reg[6:2]),
		.rdata_b (cm_bus)
	);

	////////////////////////////////////////////////////////////////////////////
	// axi write channel: address and data taken in either order
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			aw_have_reg   <= 1'b0;
			w_have_reg    <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= dcc_pkg::RESP_OKAY;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
		end else begin
			s_axi_awready <= !aw_have_reg && !(s_axi_awvalid && s_axi_awready) && !s_axi_bvalid;
			s_axi_wready  <= !w_have_reg && !(s_axi_wvalid && s_axi_wready) && !s_axi_bvalid;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have_reg <= 1'b1;
				aw_addr_reg <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have_reg <= 1'b1;
				w_data_reg <= s_axi_wdata;
				w_strb_reg <= s_axi_wstrb;
			end
			// both held: commit and answer
			if (do_write) begin
				aw_have_reg  <= 1'b0;
				w_have_reg   <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= is_mapped(aw_addr_reg) ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// software registers; masks and mode act on the very next slot
	always_ff @(posedge clk) begin
		if (reset) begin
			mode_reg <= dcc_pkg::MODE_RST;
			dce_reg  <= dcc_pkg::MASK_RST;
			dest_reg <= dcc_pkg::DEST_RST;
			bcg_reg  <= dcc_pkg::MASK_RST;
		end else if (do_write) begin
			case (aw_addr_reg)
				dcc_pkg::OFF_MODE: begin
					if (w_strb_reg[0]) mode_reg <= w_data_reg[1:0];
				end
				dcc_pkg::OFF_DCE:  dce_reg <= apply_strb(dce_reg, w_data_reg, w_strb_reg);
				dcc_pkg::OFF_DEST: begin
					if (w_strb_reg[0]) dest_reg <= w_data_reg[7:0];
				end
				dcc_pkg::OFF_BCG:  bcg_reg <= apply_strb(bcg_reg, w_data_reg, w_strb_reg);
				default: ;
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// axi read channel: two edges to rvalid so memory words come from a register
	always_ff @(posedge clk) begin
		if (reset) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= dcc_pkg::RESP_OKAY;
			rd_pend_reg   <= 1'b0;
			rd_mem_reg    <= 1'b0;
			ar_addr_reg   <= '0;
		end else begin
			s_axi_arready <= !rd_pend_reg && !rd_mem_reg && !s_axi_rvalid && !(s_axi_arvalid && s_axi_arready);
			if (s_axi_arvalid && s_axi_arready) begin
				ar_addr_reg <= s_axi_araddr;
				rd_pend_reg <= 1'b1;
			end
			// the memory port only sees the new address at the edge after the take
			if (rd_pend_reg) begin
				rd_pend_reg <= 1'b0;
				rd_mem_reg  <= 1'b1;
			end
			if (rd_mem_reg) begin
				rd_mem_reg   <= 1'b0;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= is_mapped(ar_addr_reg) ? dcc_pkg::RESP_OKAY : dcc_pkg::RESP_SLVERR;
				// state view shows the block's own decision inputs
				if (is_cm(ar_addr_reg)) begin
					s_axi_rdata <= {27'h0, cm_bus};
				end else begin
					case (ar_addr_reg)
						dcc_pkg::OFF_MODE:   s_axi_rdata <= {30'h0, mode_reg};
						dcc_pkg::OFF_DCE:    s_axi_rdata <= dce_reg;
						dcc_pkg::OFF_DEST:   s_axi_rdata <= {24'h0, dest_reg};
						dcc_pkg::OFF_BCG:    s_axi_rdata <= bcg_reg;
						dcc_pkg::OFF_SHADOW: s_axi_rdata <= shadow_reg;
						dcc_pkg::OFF_STATE:  s_axi_rdata <= {21'h0, suspended, asm_state, asm_channel};
						default:             s_axi_rdata <= 32'h0000_0000;
					endcase
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// shadow mask: loaded from the enable mask, served bit dropped at frame end
	always_ff @(posedge clk) begin
		if (reset) begin
			shadow_reg <= dcc_pkg::MASK_RST;
		end else if (shadow_load || end_of_frame) begin
			// load first, then the clear of the served channel
			shadow_reg <= (shadow_load ? dce_reg : shadow_reg)
				& ~(end_of_frame ? (32'h0000_0001 << asm_channel) : 32'h0000_0000);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// arbitration decision for the slot whose memory word has just arrived
	// other clock modes hold the state machine suspended
	assign suspended = (asm_state == dcc_pkg::ST_SUSPENDED) || (hdlc_clock_mode != dcc_pkg::ARB_CLK_MODE);

	always_comb begin
		avail = 1'b0;
		if (!mode_reg[dcc_pkg::MODE_MASTER_BIT]) begin
			// master disabled: mask alone decides, any state or clock mode
			avail = dce_reg[s1_ch_reg];
		end else if (suspended) begin
			avail = 1'b0;
		end else begin
			case (asm_state)
				dcc_pkg::ST_FULL:    avail = dce_reg[s1_ch_reg];
				dcc_pkg::ST_LIMITED: avail = dce_reg[s1_ch_reg] && shadow_reg[s1_ch_reg];
				// only the addressed channel, and only while still masked
				dcc_pkg::ST_EXPECT,
				dcc_pkg::ST_RECEIVE: avail = dce_reg[s1_ch_reg] && (s1_ch_reg == asm_channel);
				default:             avail = 1'b0;
			endcase
		end
	end

	// available sets mr or clears the c/i block bit of the memory word; anything else passes it
	always_comb begin
		word_next = cm_slot;
		if (avail) begin
			if (mode_reg[dcc_pkg::MODE_CODING_BIT]) begin
				word_next.mr = 1'b1;
			end else begin
				word_next.ci[dcc_pkg::CI_BLOCK_BIT] = 1'b0;
			end
		end
	end

	// slot pipeline: strobe, memory edge, output edge
	always_ff @(posedge clk) begin
		if (reset) begin
			s1_valid_reg <= 1'b0;
			s1_ch_reg    <= '0;
			cc_valid     <= 1'b0;
			cc_slot      <= '0;
		end else begin
			s1_valid_reg <= slot_strobe;
			s1_ch_reg    <= slot_channel;
			cc_valid     <= s1_valid_reg;
			if (s1_valid_reg) begin
				cc_slot <= {s1_ch_reg, word_next};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// transmit channel selector: latched per command, so frames may follow
	// one another every cycle with no idle gap
	always_ff @(posedge clk) begin
		if (reset) begin
			tx_select_valid <= 1'b0;
			tx_select_mask  <= '0;
		end else begin
			tx_select_valid <= transmit_frame_command;
			if (transmit_frame_command) begin
				tx_select_mask <= dest_reg[dcc_pkg::DEST_BCAST_BIT] ? bcg_reg
					: (32'h0000_0001 << dest_reg[dcc_pkg::CH_W-1:0]);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);

	sequence s_slot_decided;
		s1_valid_reg ##1 cc_valid;
	endsequence

	AST_PASS_UNMASKED: assert property (
		s1_valid_reg && !dce_reg[s1_ch_reg] |=> cc_slot.word == $past(cm_slot))
		else $error("unmasked channel did not get memory word");
	AST_SUSP_MASTER: assert property (
		s1_valid_reg && mode_reg[0] && hdlc_clock_mode != dcc_pkg::ARB_CLK_MODE |=> cc_slot.word == $past(cm_slot))
		else $error("suspended master did not pass memory word");
	AST_MASTER_OFF: assert property (
		s1_valid_reg && !mode_reg[0] && dce_reg[s1_ch_reg] && mode_reg[1] |=> cc_slot.word.mr)
		else $error("master off did not signal available");
	AST_FULL_SEL: assert property (
		s1_valid_reg && mode_reg == 2'h3 && !suspended && asm_state == dcc_pkg::ST_FULL
		&& dce_reg[s1_ch_reg] |=> cc_slot.word.mr)
		else $error("full selection did not signal available");
	AST_LIMITED: assert property (
		s1_valid_reg && mode_reg[0] && !suspended && asm_state == dcc_pkg::ST_LIMITED
		&& !shadow_reg[s1_ch_reg] |=> cc_slot.word == $past(cm_slot))
		else $error("limited selection passed a shadowed-out channel");
	AST_EXPECT_OTHER: assert property (
		s1_valid_reg && mode_reg[0] && !suspended && (asm_state == dcc_pkg::ST_EXPECT
		|| asm_state == dcc_pkg::ST_RECEIVE) && (s1_ch_reg != asm_channel || !dce_reg[s1_ch_reg])
		|=> cc_slot.word == $past(cm_slot))
		else $error("non-addressed channel was granted");
	AST_CI_CODE: assert property (
		s1_valid_reg && avail && !mode_reg[1] |=> !cc_slot.word.ci[2] && cc_slot.word.mr == $past(cm_slot.mr))
		else $error("c/i available code wrong");
	AST_SLOT_LAT: assert property (
		slot_strobe ##1 s_slot_decided |-> cc_slot.channel == $past(slot_channel, 2))
		else $error("slot answer channel mismatch");
	AST_TX_ROUTE: assert property (
		transmit_frame_command && !dest_reg[7] |=> tx_select_valid
		&& tx_select_mask == (32'h0000_0001 << $past(dest_reg[4:0])))
		else $error("single-channel route wrong");
	AST_EOF_CLEAR: assert property (
		end_of_frame |=> !shadow_reg[$past(asm_channel)])
		else $error("shadow bit not cleared at frame end");
endmodule // dcc_master
`default_nettype wire

/* sim/dcc_terminal_model.sv */
// subscriber terminal bank: asks for control channel slots and keeps what it hears
// assumes one slot request at a time from the bench, all on clk
`timescale 1ns/10ps
`default_nettype none
module dcc_terminal_model (
	input  wire logic                  clk,
	input  wire logic                  reset,
	input  wire logic                  req,
	input  wire logic [4:0]            req_ch,
	output var  logic                  slot_strobe,
	output var  logic [4:0]            slot_channel,
	input  wire logic                  cc_valid,
	input  wire dcc_pkg::dcc_cc_slot_t cc_slot,
	output var  dcc_pkg::dcc_cc_slot_t heard_slot,
	output var  logic [7:0]            heard_count
);
	// slot request; idle channel lines wander so a stale number never looks valid
	always_ff @(posedge clk) begin
		slot_strobe  <= req & ~reset;
		slot_channel <= (req | reset) ? req_ch : ~slot_channel;
	end
	// every answered slot is latched as the terminal would see it
	always_ff @(posedge clk) begin
		if (reset) begin
			heard_count <= 8'h00;
		end else if (cc_valid) begin
			heard_slot  <= cc_slot;
			heard_count <= heard_count + 8'h01;
		end
	end
endmodule // dcc_terminal_model
`default_nettype wire

/* sim/dcc_master_bench.sv */
// bench for the control channel master: axi4-lite master, slot polling, transmit selector
// assumes dcc_master and dcc_terminal_model on one 125 MHz clock
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_errors++; \
	$display("ERROR %s expected %h seen %h", nm, ex, gt); end end
module dcc_master_bench;
	logic clk = 1'b0, reset = 1'b1, awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
	logic [7:0] awa = 8'h00, ara = 8'h00, hc, old;
	logic [31:0] wd = 32'h0, rd, mask = 32'h0, shadow = 32'h0, txm;
	logic [1:0] br, rr;
	logic awr, wr, bv, arr, rv, ccv, sstb, txv, req = 1'b0, shl = 1'b0, eof = 1'b0, cmd = 1'b0, men, cod;
	logic [4:0] sch, ach = 5'h00, rch = 5'h00;
	logic [2:0] cmode = 3'h3;
	dcc_pkg::dcc_asm_state_t st = dcc_pkg::ST_SUSPENDED;
	dcc_pkg::dcc_cc_slot_t cs, heard;
	dcc_pkg::dcc_cc_word_t cm [32];
	int n_errors = 0, checks_done = 0;
	always #4 clk = ~clk;
	dcc_master dcc_master_i (.clk(clk), .reset(reset), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_wdata(wd), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wr),
		.s_axi_bresp(br), .s_axi_bvalid(bv), .s_axi_bready(bry), .s_axi_araddr(ara), .s_axi_arvalid(arv),
		.s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rry),
		.asm_state(st), .asm_channel(ach), .hdlc_clock_mode(cmode), .shadow_load(shl), .end_of_frame(eof),
		.slot_strobe(sstb), .slot_channel(sch), .cc_valid(ccv), .cc_slot(cs),
		.transmit_frame_command(cmd), .tx_select_valid(txv), .tx_select_mask(txm));
	dcc_terminal_model dcc_terminal_model_i (.clk(clk), .reset(reset), .req(req), .req_ch(rch),
		.slot_strobe(sstb), .slot_channel(sch), .cc_valid(ccv), .cc_slot(cs), .heard_slot(heard),
		.heard_count(hc));
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	// one write: address and data offered together, each dropped when taken
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d, input logic [1:0] exp);
		int i;
		awa <= a; wd <= d; awv <= 1'b1; wv <= 1'b1; bry <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (awv && awr) awv <= 1'b0;
			if (wv && wr) wv <= 1'b0;
			if (bv) break;
		end
		if (i == 50) begin n_errors++; end_of_test(); end
		`CHK("bresp", exp, br)
		bry <= 1'b0;
		@(posedge clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
		int i;
		ara <= a; arv <= 1'b1; rry <= 1'b1;
		for (i = 0; i < 50; i++) begin
			@(posedge clk);
			if (arv && arr) arv <= 1'b0;
			if (rv) break;
		end
		if (i == 50) begin n_errors++; end_of_test(); end
		`CHK("rresp", er, rr)
		`CHK("rdata", exp, rd)
		rry <= 1'b0;
		@(posedge clk);
	endtask
	// expected word worked out from mode, state and masks
	function automatic dcc_pkg::dcc_cc_slot_t exp_slot(input logic [4:0] ch);
		logic av;
		dcc_pkg::dcc_cc_word_t w;
		w = cm[ch];
		case (st)
			dcc_pkg::ST_FULL: av = 1'b1;
			dcc_pkg::ST_LIMITED: av = shadow[ch];
			default: av = (ch == ach);
		endcase
		if (!mask[ch]) av = 1'b0;
		else if (!men) av = 1'b1;
		else if (st == dcc_pkg::ST_SUSPENDED || cmode != 3'h3) av = 1'b0;
		if (av && cod) w.mr = 1'b1;
		else if (av) w.ci[dcc_pkg::CI_BLOCK_BIT] = 1'b0;
		return {ch, w};
	endfunction
	// ask the terminal model for one slot and judge the word it hears
	task automatic poll(input logic [4:0] ch);
		int i;
		old = hc; rch <= ch; req <= 1'b1;
		@(posedge clk);
		req <= 1'b0;
		for (i = 0; i < 20 && hc == old; i++) @(posedge clk);
		if (i == 20) begin n_errors++; end_of_test(); end
		`CHK("cc_slot", exp_slot(ch), heard)
	endtask
	task automatic set_mode(input logic m, input logic c);
		men = m; cod = c;
		wr_reg(dcc_pkg::OFF_MODE, (32'(c) << dcc_pkg::MODE_CODING_BIT) | 32'(m), dcc_pkg::RESP_OKAY);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset();
		rd_reg(dcc_pkg::OFF_MODE, 32'h0, dcc_pkg::RESP_OKAY);
		rd_reg(dcc_pkg::OFF_DCE, 32'h0, dcc_pkg::RESP_OKAY);
		rd_reg(dcc_pkg::OFF_DEST, 32'h0, dcc_pkg::RESP_OKAY);
		rd_reg(8'h40, 32'h0, dcc_pkg::RESP_SLVERR);
		wr_reg(8'h40, 32'hFFFF_FFFF, dcc_pkg::RESP_SLVERR);
		$display("test reset done");
	endtask
	// managed channels hold the blocked code; channel 3 is excluded but stored available
	task automatic t_init();
		for (int n = 0; n < 32; n++) begin
			cm[n] = (n == 3) ? 5'h10 : {1'b0, 4'h4 | 4'(n[1:0])};
			wr_reg(8'(dcc_pkg::OFF_CM + 8'(n * 4)), {27'h0, cm[n]}, dcc_pkg::RESP_OKAY);
		end
		rd_reg(dcc_pkg::OFF_CM + 8'h0C, 32'h0000_0010, dcc_pkg::RESP_OKAY);
		$display("test init done");
	endtask
	task automatic t_matrix();
		dcc_pkg::dcc_asm_state_t sts [5] = '{dcc_pkg::ST_SUSPENDED, dcc_pkg::ST_FULL,
			dcc_pkg::ST_LIMITED, dcc_pkg::ST_EXPECT, dcc_pkg::ST_RECEIVE};
		mask = 32'h0000_00F5;
		wr_reg(dcc_pkg::OFF_DCE, mask, dcc_pkg::RESP_OKAY);
		shl <= 1'b1; @(posedge clk); shl <= 1'b0; ach <= 5'h04; eof <= 1'b1; @(posedge clk); eof <= 1'b0;
		shadow = mask & ~32'h10;
		rd_reg(dcc_pkg::OFF_SHADOW, shadow, dcc_pkg::RESP_OKAY);
		for (int s = 0; s < 5; s++)
			for (int k = 0; k < 2; k++)
				for (int m = 0; m < 4; m++) begin
					st <= sts[s]; cmode <= k ? 3'h2 : 3'h3;
					set_mode(m[0], m[1]);
					for (int c = 0; c < 8; c++) poll(5'(c));
				end
		$display("test matrix done");
	endtask
	// the addressed channel loses access as soon as its mask bit is cleared
	task automatic t_abort();
		st <= dcc_pkg::ST_EXPECT; cmode <= 3'h3; ach <= 5'h02;
		set_mode(1'b1, 1'b1);
		rd_reg(dcc_pkg::OFF_STATE, 32'h0000_0102, dcc_pkg::RESP_OKAY);
		poll(5'h02);
		mask = 32'h0000_00F1;
		wr_reg(dcc_pkg::OFF_DCE, mask, dcc_pkg::RESP_OKAY);
		poll(5'h02);
		$display("test abort done");
	endtask
	task automatic tx_one(input logic [7:0] d, input logic [31:0] exp);
		int i;
		wr_reg(dcc_pkg::OFF_DEST, {24'h0, d}, dcc_pkg::RESP_OKAY);
		cmd <= 1'b1; @(posedge clk); cmd <= 1'b0;
		for (i = 0; i < 10 && !txv; i++) @(posedge clk);
		if (i == 10) begin n_errors++; end_of_test(); end
		`CHK("tx_select_mask", exp, txm)
	endtask
	task automatic t_tx();
		int v;
		wr_reg(dcc_pkg::OFF_BCG, 32'hA5A5_0F0F, dcc_pkg::RESP_OKAY);
		tx_one(8'h05, 32'h0000_0020);
		tx_one(8'h1F, 32'h8000_0000);
		tx_one(8'h83, 32'hA5A5_0F0F);
		v = 0;
		// the first of the two answers already stands at the second command edge
		cmd <= 1'b1; @(posedge clk); @(posedge clk); cmd <= 1'b0; v += txv;
		for (int i = 0; i < 4; i++) begin @(posedge clk); v += txv; end
		`CHK("back_to_back", 2, v)
		$display("test tx done");
	endtask
	initial begin
		men = 1'b0; cod = 1'b0;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset();
		t_init();
		t_matrix();
		t_abort();
		t_tx();
		end_of_test();
	end
endmodule // dcc_master_bench
`default_nettype wire
